// >>> hw/spp_defines.vh
// constants for the setpoint source and ramped potentiometer block
// Overview of operation
// - command source 2 digital inputs, 6 fieldbus
// - setpoint select 0,1,2,3,6,7 decoded
// - sum selections add two sources
// - raise/lower move output continuously
// - ramp-up time zero to max, 10 s
// - ramp-down time max to zero, 10 s
// - switch-on loads start value, default 0
// - config bit0 keeps setpoint across switch-off
// - auto mode bit1 selects ramp or jump
// - manual mode ramps unless the ramp time is zero
// - config bit2 enables initial rounding
// - config bit3 power-fail store with bit0
// - config resets to binary 0110
// - output clamped between min and max
// - swap signal exchanges min and max
// - manual/auto signal selects auto setpoint
// - accept signal loads preset value
// - raise/lower routable, unconnected by default
// - input function 1 on, 13 raise, 14 lower
`ifndef SPP_DEFINES_VH
`define SPP_DEFINES_VH
`define SPP_REG_CMD_SRC 8'h00
`define SPP_REG_SP_SRC 8'h04
`define SPP_REG_CONFIG 8'h08
`define SPP_REG_UP_TIME 8'h0c
`define SPP_REG_DN_TIME 8'h10
`define SPP_REG_START 8'h14
`define SPP_REG_MAX 8'h18
`define SPP_REG_MIN 8'h1c
`define SPP_REG_ROUTE 8'h20
`define SPP_REG_DI_FUNC 8'h24
`define SPP_REG_MAX_SPEED 8'h28
`define SPP_REG_PRESET 8'h2c
`define SPP_REG_STATUS 8'h30
`define SPP_REG_SETPOINT 8'h34
`define SPP_CFG_KEEP 0
`define SPP_CFG_AUTO_RAMP 1
`define SPP_CFG_ROUND 2
`define SPP_CFG_PF_STORE 3
`define SPP_CFG_RESET 4'h6
`define SPP_RAMP_TIME_RESET 16'h000a
`define SPP_START_RESET 16'h0000
`define SPP_LIMIT_RESET 16'h0000
`define SPP_MAX_SPEED_RESET 16'h05dc
`define SPP_CMD_DI 4'h2
`define SPP_CMD_BUS 4'h6
`define SPP_SP_NONE 4'h0
`define SPP_SP_POT 4'h1
`define SPP_SP_ANA 4'h2
`define SPP_SP_FIXED 4'h3
`define SPP_SP_BUS 4'h6
`define SPP_SP_ANA2 4'h7
`define SPP_SP_BUS_ANA 4'h8
`define SPP_SP_POT_ANA 4'h9
`define SPP_SP_BUS_POT 4'ha
`define SPP_FN_ON 8'h01
`define SPP_FN_RAISE 8'h0d
`define SPP_FN_LOWER 8'h0e
`define SPP_CLK_HZ 100000000
`define SPP_TICK_US 1000
`define SPP_TICK_CYCLES ((`SPP_CLK_HZ / 1000000) * `SPP_TICK_US)
`define SPP_ROUND_TICKS 8'd200
`define SPP_SRC_OFF 3'h0
`define SPP_SRC_DI0 3'h1
`define SPP_SRC_DI1 3'h2
`define SPP_SRC_DI2 3'h3
`define SPP_SRC_BUS0 3'h4
`define SPP_SRC_BUS1 3'h5
`define SPP_SRC_PANEL 3'h6
`define SPP_SRC_ONE 3'h7
`endif

// >>> hw/spp_setpoint_pot.v
// setpoint source selection and ramped potentiometer
`timescale 1ns/1ns
`default_nettype none
`include "spp_defines.vh"
module spp_setpoint_pot #(
	parameter TICK_CYCLES = `SPP_TICK_CYCLES
) (
	// clock and reset
	input wire ref_clk,
	input wire resetn,
	// wishbone slave
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	// digital input pins
	input wire [2:0] din,
	// fieldbus control word bits and setpoint
	input wire [1:0] bus_ctrl,
	input wire bus_on,
	input wire signed [15:0] bus_setpoint,
	// operator panel keys
	input wire panel_raise,
	input wire panel_lower,
	// other setpoint sources
	input wire signed [15:0] ana_setpoint,
	input wire signed [15:0] ana2_setpoint,
	input wire signed [15:0] fixed_setpoint,
	input wire signed [15:0] auto_setpoint,
	// non-volatile store
	input wire signed [15:0] nv_value,
	input wire nv_valid,
	output reg nv_write,
	output reg signed [15:0] nv_data,
	// to setpoint processing
	output reg motor_on,
	output reg signed [15:0] speed_setpoint,
	output reg signed [15:0] pot_out
);

////////////////////////////////////////////////////////////////
reg [3:0] command_source_select;
reg [3:0] setpoint_source_select;
reg [3:0] ramped_pot_config;
reg [15:0] ramp_up_time;
reg [15:0] ramp_down_time;
reg signed [15:0] pot_start_value;
reg signed [15:0] pot_max_limit;
reg signed [15:0] pot_min_limit;
reg [2:0] raise_signal_source;
reg [2:0] lower_signal_source;
reg [2:0] limit_swap_source;
reg [2:0] manual_auto_source;
reg [2:0] preset_accept_source;
reg [7:0] input0_function;
reg [7:0] input1_function;
reg [7:0] input2_function;
reg [15:0] maximum_speed;
reg signed [15:0] preset_value;
reg [2:0] din_meta;
reg [2:0] din_sync;
reg [1:0] key_meta;
reg [1:0] key_sync;
reg signed [15:0] saved_sp;
reg on_prev;
reg [31:0] tick_cnt;
reg tick;
reg [31:0] acc;
reg [7:0] round_cnt;
reg accept_prev;

////////////////////////////////////////////////////////////////
// signal routing: off, pins, bus bits, panel, constant one
function route;
	input [2:0] sel;
	input [2:0] pins;
	input [1:0] busb;
	input pnl;
	begin
		case (sel)
			`SPP_SRC_OFF: route = 1'b0;
			`SPP_SRC_DI0: route = pins[0];
			`SPP_SRC_DI1: route = pins[1];
			`SPP_SRC_DI2: route = pins[2];
			`SPP_SRC_BUS0: route = busb[0];
			`SPP_SRC_BUS1: route = busb[1];
			`SPP_SRC_PANEL: route = pnl;
			default: route = 1'b1;
		endcase
	end
endfunction

// true when any high digital input carries the given function code
function di_has;
	input [7:0] code;
	input [2:0] pins;
	input [7:0] f0;
	input [7:0] f1;
	input [7:0] f2;
	begin
		di_has = (pins[0] && f0 == code) || (pins[1] && f1 == code) ||
			(pins[2] && f2 == code);
	end
endfunction

function signed [15:0] sat_add;
	input signed [15:0] a;
	input signed [15:0] b;
	reg signed [16:0] s;
	begin
		s = {a[15], a} + {b[15], b};
		if (s > 17'sd32767)
			sat_add = 16'sh7fff;
		else if (s < -17'sd32768)
			sat_add = 16'sh8000;
		else
			sat_add = s[15:0];
	end
endfunction

////////////////////////////////////////////////////////////////
// pins and panel keys cross into ref_clk through two flops
always @(posedge ref_clk) begin
	din_meta <= din;
	din_sync <= din_meta;
	key_meta <= {panel_lower, panel_raise};
	key_sync <= key_meta;
end

wire di_on = di_has(`SPP_FN_ON, din_sync, input0_function, input1_function,
	input2_function);
wire di_raise = di_has(`SPP_FN_RAISE, din_sync, input0_function, input1_function,
	input2_function);
wire di_lower = di_has(`SPP_FN_LOWER, din_sync, input0_function, input1_function,
	input2_function);

reg next_on;
always @* begin
	case (command_source_select)
		`SPP_CMD_DI: next_on = di_on;
		`SPP_CMD_BUS: next_on = bus_on;
		default: next_on = 1'b0;
	endcase
end

// unconnected sources read 0, so raise/lower stay idle by default
wire raise = route(raise_signal_source, din_sync, bus_ctrl, key_sync[0]) |
	(command_source_select == `SPP_CMD_DI && di_raise);
wire lower = route(lower_signal_source, din_sync, bus_ctrl, key_sync[1]) |
	(command_source_select == `SPP_CMD_DI && di_lower);
wire swap = route(limit_swap_source, din_sync, bus_ctrl, 1'b0);
wire auto_mode = route(manual_auto_source, din_sync, bus_ctrl, 1'b0);
wire accept = route(preset_accept_source, din_sync, bus_ctrl, 1'b0);

wire signed [15:0] lim_hi = swap ? pot_min_limit : pot_max_limit;
wire signed [15:0] lim_lo = swap ? pot_max_limit : pot_min_limit;

function signed [15:0] clamp;
	input signed [15:0] v;
	input signed [15:0] hi;
	input signed [15:0] lo;
	begin
		if (v > hi)
			clamp = hi;
		else if (v < lo)
			clamp = lo;
		else
			clamp = v;
	end
endfunction

////////////////////////////////////////////////////////////////
// millisecond tick; ramp steps in rpm per tick accumulated in 1/65536
always @(posedge ref_clk) begin
	if (!resetn || tick_cnt >= TICK_CYCLES - 1) begin
		tick_cnt <= 32'h00000000;
		tick <= resetn;
	end else begin
		tick_cnt <= tick_cnt + 32'h00000001;
		tick <= 1'b0;
	end
end

wire manual_ramp = !auto_mode;
wire use_ramp = manual_ramp || ramped_pot_config[`SPP_CFG_AUTO_RAMP];
wire moving = auto_mode ? (auto_setpoint != pot_out) : (raise ^ lower);
wire going_up = auto_mode ? (auto_setpoint > pot_out) : raise;
wire [15:0] cur_time = going_up ? ramp_up_time : ramp_down_time;
// step = max_speed*65536/(time_s*1000); zero time means jump
wire [31:0] full_step = ({maximum_speed, 16'h0000}) /
	({16'h0000, (cur_time == 16'h0000 ? 16'h0001 : cur_time)} * 32'd1000);
// initial rounding: step grows linearly over the first ticks of a press
wire [31:0] step = (ramped_pot_config[`SPP_CFG_ROUND] && round_cnt < `SPP_ROUND_TICKS) ?
	(full_step * {24'h000000, round_cnt}) / {24'h000000, `SPP_ROUND_TICKS} :
	full_step;
wire [31:0] next_acc = acc + step;
wire signed [15:0] delta = {1'b0, next_acc[30:16]};

reg signed [15:0] next_pot;
always @* begin
	next_pot = pot_out;
	if (auto_mode && (!use_ramp || cur_time == 16'h0000))
		next_pot = auto_setpoint;
	else if (moving && !auto_mode && cur_time == 16'h0000)
		next_pot = raise ? lim_hi : lim_lo;
	else if (moving && going_up) begin
		next_pot = sat_add(pot_out, delta);
		if (auto_mode && next_pot > auto_setpoint)
			next_pot = auto_setpoint;
	end else if (moving) begin
		next_pot = sat_add(pot_out, -delta);
		if (auto_mode && next_pot < auto_setpoint)
			next_pot = auto_setpoint;
	end
end

wire keep = ramped_pot_config[`SPP_CFG_KEEP];
wire pf_store = keep && ramped_pot_config[`SPP_CFG_PF_STORE];

always @(posedge ref_clk) begin
	if (!resetn) begin
		pot_out <= `SPP_START_RESET;
		saved_sp <= `SPP_START_RESET;
		on_prev <= 1'b0;
		motor_on <= 1'b0;
		acc <= 32'h00000000;
		round_cnt <= 8'h00;
		accept_prev <= 1'b0;
		nv_write <= 1'b0;
		nv_data <= 16'sh0000;
	end else begin
		motor_on <= next_on;
		on_prev <= next_on;
		accept_prev <= accept;
		nv_write <= 1'b0;
		if (accept && !accept_prev) begin
			pot_out <= clamp(preset_value, lim_hi, lim_lo);
		end else if (next_on && !on_prev) begin
			if (keep)
				pot_out <= clamp(saved_sp, lim_hi, lim_lo);
			else
				pot_out <= clamp(pot_start_value, lim_hi, lim_lo);
			acc <= 32'h00000000;
			round_cnt <= 8'h00;
		end else if (!next_on && on_prev) begin
			saved_sp <= pot_out;
			nv_write <= pf_store;
			nv_data <= pot_out;
		end else if (next_on && tick) begin
			pot_out <= clamp(next_pot, lim_hi, lim_lo);
			acc <= {16'h0000, next_acc[15:0]};
			if (!moving)
				round_cnt <= 8'h00;
			else if (round_cnt != 8'hff)
				round_cnt <= round_cnt + 8'h01;
		end
		if (pf_store && nv_valid && !motor_on && !on_prev)
			saved_sp <= nv_value;
	end
end

////////////////////////////////////////////////////////////////
reg signed [15:0] next_speed;
always @* begin
	case (setpoint_source_select)
		`SPP_SP_NONE: next_speed = 16'sh0000;
		`SPP_SP_POT: next_speed = pot_out;
		`SPP_SP_ANA: next_speed = ana_setpoint;
		`SPP_SP_FIXED: next_speed = fixed_setpoint;
		`SPP_SP_BUS: next_speed = bus_setpoint;
		`SPP_SP_ANA2: next_speed = ana2_setpoint;
		`SPP_SP_BUS_ANA: next_speed = sat_add(bus_setpoint, ana_setpoint);
		`SPP_SP_POT_ANA: next_speed = sat_add(pot_out, ana_setpoint);
		`SPP_SP_BUS_POT: next_speed = sat_add(bus_setpoint, pot_out);
		default: next_speed = 16'sh0000;
	endcase
end

always @(posedge ref_clk) begin
	if (!resetn)
		speed_setpoint <= 16'sh0000;
	else
		speed_setpoint <= next_speed;
end

////////////////////////////////////////////////////////////////
// wishbone: ack one cycle after strobe, dropped the next cycle
wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
wire wb_wr = wb_req && wb_we_i && wb_sel_i[0];
wire wb_wr_hi = wb_req && wb_we_i && wb_sel_i[1];

always @(posedge ref_clk) begin
	if (!resetn) begin
		wb_ack_o <= 1'b0;
		wb_dat_o <= 32'h00000000;
		command_source_select <= `SPP_CMD_DI;
		setpoint_source_select <= `SPP_SP_POT;
		ramped_pot_config <= `SPP_CFG_RESET;
		ramp_up_time <= `SPP_RAMP_TIME_RESET;
		ramp_down_time <= `SPP_RAMP_TIME_RESET;
		pot_start_value <= `SPP_START_RESET;
		pot_max_limit <= `SPP_LIMIT_RESET;
		pot_min_limit <= `SPP_LIMIT_RESET;
		raise_signal_source <= `SPP_SRC_OFF;
		lower_signal_source <= `SPP_SRC_OFF;
		limit_swap_source <= `SPP_SRC_OFF;
		manual_auto_source <= `SPP_SRC_OFF;
		preset_accept_source <= `SPP_SRC_OFF;
		input0_function <= `SPP_FN_ON;
		input1_function <= 8'h00;
		input2_function <= 8'h00;
		maximum_speed <= `SPP_MAX_SPEED_RESET;
		preset_value <= 16'sh0000;
	end else begin
		wb_ack_o <= wb_req;
		if (wb_wr) begin
			case (wb_adr_i)
				`SPP_REG_CMD_SRC: command_source_select <= wb_dat_i[3:0];
				`SPP_REG_SP_SRC: setpoint_source_select <= wb_dat_i[3:0];
				`SPP_REG_CONFIG: ramped_pot_config <= wb_dat_i[3:0];
				`SPP_REG_UP_TIME: ramp_up_time[7:0] <= wb_dat_i[7:0];
				`SPP_REG_DN_TIME: ramp_down_time[7:0] <= wb_dat_i[7:0];
				`SPP_REG_START: pot_start_value[7:0] <= wb_dat_i[7:0];
				`SPP_REG_MAX: pot_max_limit[7:0] <= wb_dat_i[7:0];
				`SPP_REG_MIN: pot_min_limit[7:0] <= wb_dat_i[7:0];
				`SPP_REG_ROUTE: begin
					raise_signal_source <= wb_dat_i[2:0];
					lower_signal_source <= wb_dat_i[6:4];
				end
				`SPP_REG_DI_FUNC: input0_function <= wb_dat_i[7:0];
				`SPP_REG_MAX_SPEED: maximum_speed[7:0] <= wb_dat_i[7:0];
				`SPP_REG_PRESET: preset_value[7:0] <= wb_dat_i[7:0];
				default: ;
			endcase
		end
		if (wb_wr_hi) begin
			case (wb_adr_i)
				`SPP_REG_UP_TIME: ramp_up_time[15:8] <= wb_dat_i[15:8];
				`SPP_REG_DN_TIME: ramp_down_time[15:8] <= wb_dat_i[15:8];
				`SPP_REG_START: pot_start_value[15:8] <= wb_dat_i[15:8];
				`SPP_REG_MAX: pot_max_limit[15:8] <= wb_dat_i[15:8];
				`SPP_REG_MIN: pot_min_limit[15:8] <= wb_dat_i[15:8];
				`SPP_REG_ROUTE: begin
					limit_swap_source <= wb_dat_i[10:8];
					manual_auto_source <= wb_dat_i[14:12];
				end
				`SPP_REG_DI_FUNC: input1_function <= wb_dat_i[15:8];
				`SPP_REG_MAX_SPEED: maximum_speed[15:8] <= wb_dat_i[15:8];
				`SPP_REG_PRESET: preset_value[15:8] <= wb_dat_i[15:8];
				default: ;
			endcase
		end
		if (wb_req && wb_we_i && wb_sel_i[2]) begin
			if (wb_adr_i == `SPP_REG_ROUTE)
				preset_accept_source <= wb_dat_i[18:16];
			if (wb_adr_i == `SPP_REG_DI_FUNC)
				input2_function <= wb_dat_i[23:16];
		end
		// unmapped reads return zero, writes ignored
		if (wb_req && !wb_we_i) begin
			case (wb_adr_i)
				`SPP_REG_CMD_SRC: wb_dat_o <= {28'h0000000, command_source_select};
				`SPP_REG_SP_SRC: wb_dat_o <= {28'h0000000, setpoint_source_select};
				`SPP_REG_CONFIG: wb_dat_o <= {28'h0000000, ramped_pot_config};
				`SPP_REG_UP_TIME: wb_dat_o <= {16'h0000, ramp_up_time};
				`SPP_REG_DN_TIME: wb_dat_o <= {16'h0000, ramp_down_time};
				`SPP_REG_START: wb_dat_o <= {16'h0000, pot_start_value};
				`SPP_REG_MAX: wb_dat_o <= {16'h0000, pot_max_limit};
				`SPP_REG_MIN: wb_dat_o <= {16'h0000, pot_min_limit};
				`SPP_REG_ROUTE: wb_dat_o <= {13'h0, preset_accept_source, 1'b0,
					manual_auto_source, 1'b0, limit_swap_source, 1'b0,
					lower_signal_source, 1'b0, raise_signal_source};
				`SPP_REG_DI_FUNC: wb_dat_o <= {8'h00, input2_function,
					input1_function, input0_function};
				`SPP_REG_MAX_SPEED: wb_dat_o <= {16'h0000, maximum_speed};
				`SPP_REG_PRESET: wb_dat_o <= {16'h0000, preset_value};
				`SPP_REG_STATUS: wb_dat_o <= {26'h0, auto_mode, swap, lower,
					raise, on_prev, motor_on};
				`SPP_REG_SETPOINT: wb_dat_o <= {speed_setpoint, pot_out};
				default: wb_dat_o <= 32'h00000000;
			endcase
		end
	end
end

endmodule
`default_nettype wire

// >>> sim/spp_setpoint_pot_sva.sv
// port assertions for the setpoint block
`timescale 1ns/1ns
`default_nettype none
module spp_setpoint_pot_sva (
	// clock and reset
	input wire logic ref_clk,
	input wire logic resetn,
	// wishbone
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	// outputs
	input wire logic nv_write,
	input wire logic motor_on,
	input wire logic signed [15:0] pot_out
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!resetn);
	property p_ack_take; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack_take: assert property (p_ack_take) else $error("request not acked");
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than a cycle");
	property p_ack_req; wb_ack_o |-> $past(wb_stb_i); endproperty
	a_ack_req: assert property (p_ack_req) else $error("ack without request");
	property p_dat_hold; $changed(wb_dat_o) |-> wb_ack_o; endproperty
	a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
	property p_unm; wb_ack_o && !wb_we_i && wb_adr_i > 8'h34 |-> wb_dat_o == 32'h0; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	// read path samples one cycle early, so only judged when pot is steady
	property p_sp_rd;
		wb_ack_o && !wb_we_i && wb_adr_i == 8'h34 && $stable(pot_out) |-> wb_dat_o[15:0] == pot_out;
	endproperty
	a_sp_rd: assert property (p_sp_rd) else $error("setpoint read wrong");
	property p_rst;
		disable iff (1'b0) !resetn |=> !wb_ack_o && !motor_on && !nv_write && pot_out == 16'sh0;
	endproperty
	a_rst: assert property (p_rst) else $error("outputs not cleared");
	property p_nv_pulse; nv_write |=> !nv_write; endproperty
	a_nv_pulse: assert property (p_nv_pulse) else $error("store pulse too long");
	property p_nv_off; nv_write |-> !motor_on; endproperty
	a_nv_off: assert property (p_nv_off) else $error("store while running");
	c_on: cover property ($rose(motor_on));
	c_nv: cover property (nv_write);
	c_sp: cover property (wb_ack_o && wb_adr_i == 8'h34);
endmodule
`default_nettype wire

// >>> sim/spp_nv_store.sv
// non-volatile setpoint store on the far side
`timescale 1ns/1ns
`default_nettype none
module spp_nv_store (
	// clock
	input wire logic ref_clk,
	// store port
	input wire logic nv_write,
	input wire logic signed [15:0] nv_data,
	output logic signed [15:0] nv_value,
	output logic nv_valid,
	// write count
	output int n_wr
);
	// no reset: the store outlives the block's reset
	initial begin
		nv_value = 16'sh0;
		nv_valid = 1'b0;
		n_wr = 0;
	end
	always @(posedge ref_clk) begin
		if (nv_write) begin
			nv_value <= nv_data;
			nv_valid <= 1'b1;
			n_wr <= n_wr + 1;
		end
	end
endmodule
`default_nettype wire

// >>> sim/setpoint_source_and_ramped_pot_test.sv
// testbench for the setpoint block
`timescale 1ns/1ns
`default_nettype none
`include "spp_defines.vh"
module setpoint_source_and_ramped_pot_test;
	logic ref_clk = 0, resetn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, bus_on = 0;
	logic [7:0] wb_adr_i = 0;
	logic [31:0] wb_dat_i = 0, q;
	logic [2:0] din = 0;
	logic [1:0] bus_ctrl = 0;
	logic signed [15:0] bus_setpoint = 111, ana_setpoint = 222, ana2_setpoint = 333;
	logic signed [15:0] fixed_setpoint = 444, auto_setpoint = 0;
	wire [31:0] wb_dat_o;
	wire wb_ack_o, nv_write, nv_valid, motor_on;
	wire signed [15:0] nv_data, nv_value, speed_setpoint, pot_out;
	int error_cnt = 0, n_tests = 0, nv_cnt;
	logic [7:0] ra [12] = '{0, 4, 8, 'hc, 'h10, 'h14, 'h18, 'h1c, 'h20, 'h24, 'h28, 'h3c};
	logic [31:0] re [12] = '{2, 1, 6, 'ha, 'ha, 0, 0, 0, 0, 1, 'h5dc, 0};
	logic [7:0] sc [9] = '{0, 1, 2, 3, 6, 7, 8, 9, 10};
	logic [31:0] se [9] = '{0, 100, 222, 444, 111, 333, 333, 322, 211};
	spp_setpoint_pot #(.TICK_CYCLES(10)) spp_setpoint_pot_i (.ref_clk, .resetn, .wb_cyc_i,
		.wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o, .din,
		.bus_ctrl, .bus_on, .bus_setpoint, .panel_raise(1'b0), .panel_lower(1'b0), .ana_setpoint,
		.ana2_setpoint, .fixed_setpoint, .auto_setpoint, .nv_value, .nv_valid, .nv_write,
		.nv_data, .motor_on, .speed_setpoint, .pot_out);
	spp_nv_store spp_nv_store_i (.ref_clk, .nv_write, .nv_data, .nv_value, .nv_valid,
		.n_wr(nv_cnt));
	always #5 ref_clk = ~ref_clk;
	////////////////////////////////////////////////////////////////////////////////
	task chk(input logic [31:0] s, input logic [31:0] e);
		n_tests++;
		if (s !== e) begin
			error_cnt++;
			$display("unexpected at %0t: got %0h want %0h", $time, s, e);
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1;
		wb_stb_i <= 1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		// no cycle limit here: only the watchdog ends a wait
		@(posedge ref_clk);
		while (wb_ack_o !== 1'b1)
			@(posedge ref_clk);
		q = wb_dat_o;
		wb_cyc_i <= 0;
		wb_stb_i <= 0;
		@(posedge ref_clk);
	endtask
	task wt(int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task t_regs;
		for (int i = 0; i < 12; i++) begin
			wb(0, ra[i], 0);
			chk(q, re[i]);
		end
	endtask
	task t_ramp;
		wb(1, `SPP_REG_MAX, 1000);
		wb(1, `SPP_REG_START, 100);
		wb(1, `SPP_REG_UP_TIME, 1);
		wb(1, `SPP_REG_DN_TIME, 1);
		wb(1, `SPP_REG_CONFIG, 0);
		wb(1, `SPP_REG_DI_FUNC, 32'h000e0d01);
		wb(1, `SPP_REG_ROUTE, 32'h32);
		din <= 3'b001;
		wt(10);
		chk(motor_on, 1);
		chk(pot_out, 100);
		// 1.5 rpm per tick, two-flop sync and tick phase give the slack
		din <= 3'b011;
		wt(1000);
		din <= 3'b001;
		wt(20);
		chk(pot_out >= 246 && pot_out <= 254, 1);
		din <= 3'b101;
		wt(600);
		din <= 3'b111;
		wt(200);
		chk(pot_out >= 155 && pot_out <= 165, 1);
		wb(1, `SPP_REG_MAX, 300);
		wb(1, `SPP_REG_MIN, 50);
		din <= 3'b011;
		wt(2000);
		chk(pot_out, 300);
		wb(1, `SPP_REG_ROUTE, 32'h732);
		wt(30);
		chk(pot_out, 50);
		din <= 3'b001;
		wb(1, `SPP_REG_ROUTE, 32'h32);
	endtask
	task t_keep;
		wb(1, `SPP_REG_CONFIG, 9);
		din <= 3'b000;
		wt(10);
		chk(nv_value, 50);
		din <= 3'b001;
		wt(10);
		chk(pot_out, 50);
		wb(1, `SPP_REG_CONFIG, 0);
		din <= 3'b000;
		wt(10);
		din <= 3'b001;
		wt(10);
		chk(pot_out, 100);
		chk(nv_cnt, 1);
	endtask
	task t_sel;
		for (int i = 0; i < 9; i++) begin
			wb(1, `SPP_REG_SP_SRC, sc[i]);
			wt(3);
			chk(speed_setpoint, se[i]);
		end
		wb(0, `SPP_REG_SETPOINT, 0);
		chk(q[15:0], 100);
	endtask
	task t_auto;
		auto_setpoint <= 250;
		wb(1, `SPP_REG_ROUTE, 32'h7032);
		wt(20);
		chk(pot_out, 250);
		wb(1, `SPP_REG_CONFIG, 2);
		auto_setpoint <= 150;
		wt(100);
		chk(pot_out > 150 && pot_out < 250, 1);
		wb(1, `SPP_REG_PRESET, 77);
		wb(1, `SPP_REG_ROUTE, 32'h40032);
		bus_ctrl <= 2'b01;
		wt(20);
		chk(pot_out, 77);
	endtask
	task t_bus;
		wb(1, `SPP_REG_CMD_SRC, 6);
		wt(10);
		chk(motor_on, 0);
		bus_on <= 1;
		wt(10);
		chk(motor_on, 1);
		chk(pot_out, 100);
	endtask
	task t_power;
		wb(1, `SPP_REG_CONFIG, 9);
		bus_on <= 0;
		din <= 3'b000;
		wt(10);
		chk(nv_value, 100);
		// power failure: the block resets, the far-side store keeps its word
		resetn <= 0;
		wt(12);
		resetn <= 1;
		wb(1, `SPP_REG_MAX, 300);
		wb(1, `SPP_REG_CONFIG, 9);
		wt(3);
		din <= 3'b001;
		wt(10);
		chk(pot_out, 100);
		chk(nv_cnt, 2);
	endtask
	task t_round;
		wb(1, `SPP_REG_UP_TIME, 1);
		wb(1, `SPP_REG_DI_FUNC, 32'h0d01);
		wb(1, `SPP_REG_CONFIG, 4);
		// short press: rounding keeps the change near 1.5 rpm instead of 30
		din <= 3'b011;
		wt(200);
		din <= 3'b001;
		wt(20);
		chk(pot_out >= 100 && pot_out <= 104, 1);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		wt(12);
		resetn <= 1;
		t_regs;
		t_ramp;
		t_keep;
		t_sel;
		t_auto;
		t_bus;
		t_power;
		t_round;
		report_and_stop;
	end
	// whole run is near 4500 cycles
	initial begin
		wt(40000);
		error_cnt++;
		report_and_stop;
	end
endmodule
bind spp_setpoint_pot spp_setpoint_pot_sva spp_setpoint_pot_sva_i (.ref_clk, .resetn,
	.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .nv_write, .motor_on,
	.pot_out);
`default_nettype wire
